// ==== csb_core.sv ====
`timescale 1ns/10ps
module csb_core (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rstn,
    // Programmer side, valid in flash mode.
    input wire logic flash_mode,
    input wire logic [1:0] prog_op,
    input wire logic [15:0] prog_addr,
    input wire logic [7:0] prog_wdata,
    input wire logic [7:0] array_rdata,
    output logic [7:0] prog_rdata,
    output logic prog_rvalid,
    output logic array_we,
    output logic array_erase,
    // Core table-read side.
    input wire logic movc_req,
    input wire logic movc_from_int,
    input wire logic movc_to_int,
    output logic movc_int_ok,
    // Port 0 output path.
    input wire logic [7:0] p0_data,
    output logic [7:0] p0_pin,
    // Current security state.
    output logic lock_n,
    output logic movc_inh_n,
    output logic enc_n
);
    typedef struct packed {
        logic [2:0] sec;
        logic [7:0] rdata;
        logic rvalid;
        logic we;
        logic erase;
        logic int_ok;
        logic [7:0] pin;
    } csb_state_t;

    csb_state_t st_r;
    csb_state_t st_nxt;
    logic sel_sec;
    logic locked;

    // Decodes one programmer operation; only flash mode lets any through.
    function automatic logic csb_op_is(input logic mode,
                                       input logic [1:0] op,
                                       input logic [1:0] code);
        return mode && (op == code);
    endfunction : csb_op_is

    ///////////////////////////////////////////////////////////////////////
    always_comb begin
        sel_sec = flash_mode
            && (prog_addr == csb_pkg::SEC_ADDR);
        locked = !st_r.sec[csb_pkg::LOCK_BIT];
        st_nxt = st_r;
        st_nxt.rvalid = 1'b0;
        st_nxt.we = 1'b0;
        st_nxt.erase = 1'b0;
        st_nxt.rdata = 8'h00;
        if (flash_mode) begin
            case (prog_op)
                csb_pkg::OP_READ: begin
                    st_nxt.rvalid = 1'b1;
                    if (locked) begin
                        st_nxt.rdata = 8'hff;
                    end else if (sel_sec) begin
                        st_nxt.rdata = {5'h1f, st_r.sec};
                    end else begin
                        st_nxt.rdata = array_rdata;
                    end
                end
                csb_pkg::OP_PROG: begin
                    // Programming can only clear bits; only an erase sets them back to one.
                    if (!locked && sel_sec) begin
                        st_nxt.sec = st_r.sec & prog_wdata[2:0];
                    end else if (!locked) begin
                        st_nxt.we = 1'b1;
                    end
                end
                csb_pkg::OP_ERASE: begin
                    st_nxt.sec = csb_pkg::SEC_ERASED;
                    st_nxt.erase = 1'b1;
                end
                default: begin
                end
            endcase
        end
        st_nxt.int_ok = !movc_to_int || movc_from_int
            || st_r.sec[csb_pkg::MOVC_BIT];
        if (!movc_req) begin
            st_nxt.int_ok = 1'b1;
        end
        if (!st_r.sec[csb_pkg::ENC_BIT]) begin
            st_nxt.pin = p0_data ^ csb_pkg::ENC_KEY;
        end else begin
            st_nxt.pin = p0_data;
        end
    end

    ///////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            st_r.rdata <= 8'h00;
            st_r.rvalid <= 1'b0;
            st_r.we <= 1'b0;
            st_r.erase <= 1'b0;
            st_r.int_ok <= 1'b1;
            st_r.pin <= 8'h00;
            // Security bits are nonvolatile: system reset leaves them alone.
            st_r.sec <= st_r.sec;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prog_rdata = st_r.rdata;
    assign prog_rvalid = st_r.rvalid;
    assign array_we = st_r.we;
    assign array_erase = st_r.erase;
    assign movc_int_ok = st_r.int_ok;
    assign p0_pin = st_r.pin;
    assign lock_n = st_r.sec[csb_pkg::LOCK_BIT];
    assign movc_inh_n = st_r.sec[csb_pkg::MOVC_BIT];
    assign enc_n = st_r.sec[csb_pkg::ENC_BIT];

    ///////////////////////////////////////////////////////////////////////
    // The sampled reset keeps out the release edge, where the nonvolatile
    // bits may still be unknown before the first erase.
    property p_sec_no_rise;
        @(posedge sys_clk) disable iff (!rstn)
        rstn && !csb_op_is(flash_mode, prog_op, csb_pkg::OP_ERASE)
            |=> ((st_r.sec & ~$past(st_r.sec)) == 3'h0);
    endproperty
    a_sec_no_rise: assert property (p_sec_no_rise)
        else $error("bit rose");

    property p_locked_read;
        @(posedge sys_clk) disable iff (!rstn)
        flash_mode && prog_op == csb_pkg::OP_READ && !lock_n
            |=> prog_rvalid && prog_rdata == 8'hff;
    endproperty
    a_locked_read: assert property (p_locked_read)
        else $error("lock leak");

    property p_erase_all;
        @(posedge sys_clk) disable iff (!rstn)
        flash_mode && prog_op == csb_pkg::OP_ERASE
            |=> array_erase && lock_n && movc_inh_n && enc_n;
    endproperty
    a_erase_all: assert property (p_erase_all)
        else $error("erase fail");

    property p_normal_no_touch;
        @(posedge sys_clk) disable iff (!rstn)
        rstn && !flash_mode
            |=> $stable(st_r.sec) && !prog_rvalid && !array_we;
    endproperty
    a_normal_no_touch: assert property (p_normal_no_touch)
        else $error("normal access");

    property p_sec_select;
        @(posedge sys_clk) disable iff (!rstn)
        flash_mode && prog_op == csb_pkg::OP_READ && lock_n
            && prog_addr == csb_pkg::SEC_ADDR
            |=> prog_rdata == {5'h1f, $past(st_r.sec)};
    endproperty
    a_sec_select: assert property (p_sec_select)
        else $error("sec read");

    property p_movc_block;
        @(posedge sys_clk) disable iff (!rstn)
        movc_req && !movc_from_int && movc_to_int && !movc_inh_n
            |=> !movc_int_ok;
    endproperty
    a_movc_block: assert property (p_movc_block)
        else $error("movc leak");

    property p_movc_internal;
        @(posedge sys_clk) disable iff (!rstn)
        movc_req && movc_from_int |=> movc_int_ok;
    endproperty
    a_movc_internal: assert property (p_movc_internal)
        else $error("movc int");

    property p_movc_free;
        @(posedge sys_clk) disable iff (!rstn)
        movc_req && movc_inh_n |=> movc_int_ok;
    endproperty
    a_movc_free: assert property (p_movc_free)
        else $error("movc free");

    property p_encode;
        @(posedge sys_clk) disable iff (!rstn)
        !enc_n |=> p0_pin == ($past(p0_data) ^ csb_pkg::ENC_KEY);
    endproperty
    a_encode: assert property (p_encode)
        else $error("no encode");

    property p_enc_stays;
        @(posedge sys_clk) disable iff (!rstn)
        !enc_n && !(flash_mode && prog_op == csb_pkg::OP_ERASE) |=> !enc_n;
    endproperty
    a_enc_stays: assert property (p_enc_stays)
        else $error("enc reset");

    property p_locked_prog;
        @(posedge sys_clk) disable iff (!rstn)
        csb_op_is(flash_mode, prog_op, csb_pkg::OP_PROG) && !lock_n
            |=> !array_we && $stable(st_r.sec);
    endproperty
    a_locked_prog: assert property (p_locked_prog)
        else $error("locked prog");

    property p_sec_program;
        @(posedge sys_clk) disable iff (!rstn)
        csb_op_is(flash_mode, prog_op, csb_pkg::OP_PROG) && lock_n
            && prog_addr == csb_pkg::SEC_ADDR
            |=> st_r.sec == ($past(st_r.sec) & $past(prog_wdata[2:0]));
    endproperty
    a_sec_program: assert property (p_sec_program)
        else $error("sec program");
endmodule : csb_core

// ==== csb_pkg.sv ====
package csb_pkg;
    // Security register location in flash address space.
    localparam logic [15:0] SEC_ADDR = 16'hffff;
    // Security register bit positions.
    localparam int LOCK_BIT = 0;
    localparam int MOVC_BIT = 1;
    localparam int ENC_BIT = 2;
    // Reset value of the register after a whole-chip erase.
    localparam logic [2:0] SEC_ERASED = 3'h7;
    // Port 0 encoding key; the value is arbitrary.
    localparam logic [7:0] ENC_KEY = 8'ha5;
    // Programmer operation encodings.
    localparam logic [1:0] OP_IDLE = 2'h0;
    localparam logic [1:0] OP_READ = 2'h1;
    localparam logic [1:0] OP_PROG = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
endpackage : csb_pkg

// ==== csb_prog_model.sv ====
`timescale 1ns/10ps
module csb_prog_model (
    // Clock.
    input wire logic sys_clk,
    // Programmer lines.
    output logic [1:0] prog_op,
    output logic [15:0] prog_addr,
    output logic [7:0] prog_wdata,
    // Flash array.
    input wire logic array_we,
    input wire logic array_erase,
    output logic [7:0] array_rdata
);
    logic [7:0] mem [256];
    logic [15:0] addr_q;
    logic [7:0] data_q;
    initial begin
        prog_op = csb_pkg::OP_IDLE;
        prog_addr = 16'h0000;
        prog_wdata = 8'h00;
    end
    assign array_rdata = mem[prog_addr[7:0]];
    // The write strobe lags its request by one edge, so the address is kept.
    always @(posedge sys_clk) begin
        addr_q <= prog_addr;
        data_q <= prog_wdata;
        if (array_erase) begin
            foreach (mem[i]) mem[i] <= 8'hff;
        end else if (array_we) begin
            mem[addr_q[7:0]] <= mem[addr_q[7:0]] & data_q;
        end
    end
    // One request is held over one sampling edge, then prog_op goes idle; address and data are kept.
    task automatic op(input logic [1:0] c, input logic [15:0] a,
                      input logic [7:0] d);
        @(posedge sys_clk);
        prog_op <= c;
        prog_addr <= a;
        prog_wdata <= d;
        @(posedge sys_clk);
        prog_op <= csb_pkg::OP_IDLE;
    endtask : op
endmodule : csb_prog_model

// ==== tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
    // Flash mode is up from the start, so the first erase meets the first
    // edge after reset is released.
    logic sys_clk = 0, rstn = 0, flash_mode = 1;
    logic movc_req = 0, movc_from_int = 0, movc_to_int = 0;
    logic [7:0] p0_data = 8'h00, d;
    logic [1:0] op;
    logic [15:0] addr;
    logic [7:0] wdata, rdata, prdata, p0_pin, sh [4];
    logic rvalid, we, erase, int_ok, lock_n, inh_n, enc_n;
    int fails = 0, samples_checked = 0, cycles = 0;
    always #12.5 sys_clk = ~sys_clk;
    csb_prog_model u_prog (.sys_clk(sys_clk), .prog_op(op),
        .prog_addr(addr), .prog_wdata(wdata), .array_we(we),
        .array_erase(erase), .array_rdata(rdata));
    csb_core u_dut (.sys_clk(sys_clk), .rstn(rstn), .flash_mode(flash_mode),
        .prog_op(op), .prog_addr(addr), .prog_wdata(wdata),
        .array_rdata(rdata), .prog_rdata(prdata), .prog_rvalid(rvalid),
        .array_we(we), .array_erase(erase), .movc_req(movc_req),
        .movc_from_int(movc_from_int), .movc_to_int(movc_to_int),
        .movc_int_ok(int_ok), .p0_data(p0_data), .p0_pin(p0_pin),
        .lock_n(lock_n), .movc_inh_n(inh_n), .enc_n(enc_n));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic prog(logic [1:0] c, logic [15:0] a, logic [7:0] v);
        u_prog.op(c, a, v);
        #1;
    endtask : prog
    task automatic rd(logic [15:0] a, logic [7:0] e);
        prog(csb_pkg::OP_READ, a, 8'h00);
        chk("prog_rvalid", 8'h01, {7'h0, rvalid});
        chk("prog_rdata", e, prdata);
    endtask : rd
    task automatic sec(logic [2:0] e);
        chk("security_bits", {5'h0, e}, {5'h0, enc_n, inh_n, lock_n});
    endtask : sec
    task automatic movc(logic inh);
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            {movc_req, movc_from_int, movc_to_int} <= {1'b1, 2'(i)};
            repeat (2) @(posedge sys_clk);
            #1;
            chk("movc_int_ok", {7'h0, inh | i[1] | !i[0]}, {7'h0, int_ok});
        end
    endtask : movc
    task automatic p0(logic on_n);
        repeat (4) begin
            @(posedge sys_clk);
            d = 8'($urandom);
            p0_data <= d;
            @(posedge sys_clk);
            #1;
            chk("p0_pin", on_n ? d : d ^ csb_pkg::ENC_KEY, p0_pin);
        end
    endtask : p0
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            summarize();
        end
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
    end
    initial begin
        void'($urandom(32'h1eddee9b));
        @(posedge sys_clk);
        prog(csb_pkg::OP_ERASE, 16'h0, 8'h00);
        chk("array_erase", 8'h01, {7'h0, erase});
        sec(3'h7);
        rd(csb_pkg::SEC_ADDR, 8'hff);
        foreach (sh[i]) sh[i] = 8'($urandom);
        foreach (sh[i]) prog(csb_pkg::OP_PROG, 16'(i), sh[i]);
        foreach (sh[i]) rd(16'(i), sh[i]);
        p0(1'b1);
        $display("test array done");
        @(posedge sys_clk) flash_mode <= 0;
        prog(csb_pkg::OP_PROG, csb_pkg::SEC_ADDR, 8'hf8);
        sec(3'h7);
        prog(csb_pkg::OP_READ, 16'h0, 8'h00);
        chk("prog_rvalid", 8'h00, {7'h0, rvalid});
        @(posedge sys_clk) flash_mode <= 1;
        movc(1'b1);
        prog(csb_pkg::OP_PROG, csb_pkg::SEC_ADDR, 8'hfd);
        prog(csb_pkg::OP_PROG, csb_pkg::SEC_ADDR, 8'hff);
        sec(3'h5);
        movc(1'b0);
        prog(csb_pkg::OP_PROG, csb_pkg::SEC_ADDR, 8'hf9);
        p0(1'b0);
        $display("test movc and encryption done");
        // The lock goes last, once the array has been verified.
        prog(csb_pkg::OP_PROG, csb_pkg::SEC_ADDR, 8'hf8);
        sec(3'h0);
        rd(16'h0, 8'hff);
        rd(csb_pkg::SEC_ADDR, 8'hff);
        prog(csb_pkg::OP_PROG, 16'h1, 8'h00);
        chk("array_we", 8'h00, {7'h0, we});
        prog(csb_pkg::OP_ERASE, 16'h0, 8'h00);
        sec(3'h7);
        p0(1'b1);
        $display("test lock and erase done");
        summarize();
    end
endmodule : tb_top
